// ### hw/smcf_defs.svh
// Constants for the SPI memory command front end
`ifndef SMCF_DEFS_SVH
`define SMCF_DEFS_SVH
`define SMCF_OP_SET_WL 8'h06
`define SMCF_OP_CLR_WL 8'h04
`define SMCF_OP_STAT_RD 8'h05
`define SMCF_OP_STAT_WR 8'h01
`define SMCF_OP_MEM_RD 8'h03
`define SMCF_OP_FAST_RD 8'h0b
`define SMCF_OP_MEM_WR 8'h02
`define SMCF_OP_SLEEP 8'hb9
`define SMCF_OP_ID_RD 8'h9f
`define SMCF_BITS_PER_BYTE 4'h8
`define SMCF_LAST_BIT 3'h7
`define SMCF_ADDR_BITS 14
`define SMCF_STAT_WL_BIT 1
`define SMCF_ADDR_BYTES 2'h2
`define SMCF_FAST_DUMMY 2'h3
`endif

// ### hw/smcf_frontend.sv
// SPI slave command front end: framing, opcode decode, write latch
`timescale 1ns/1ps
`default_nettype none
`include "smcf_defs.svh"
module smcf_frontend #(
  parameter int ADDR_BITS = `SMCF_ADDR_BITS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [7:0] rd_data,
  output logic so_o,
  output logic so_oe,
  output logic write_latch_flag,
  output logic mode3_q,
  output smcf_pkg::smcf_cmd_t cmd_q,
  output logic cmd_valid_q,
  output logic [ADDR_BITS-1:0] addr_q,
  output logic addr_valid_q,
  output logic [7:0] wr_data_q,
  output logic wr_strobe_q,
  output logic rd_strobe_q
);
  function automatic smcf_pkg::smcf_cmd_t decode_op(input logic [7:0] op);
    case (op)
      `SMCF_OP_SET_WL: decode_op = smcf_pkg::SMCF_CMD_SET_WL;
      `SMCF_OP_CLR_WL: decode_op = smcf_pkg::SMCF_CMD_CLR_WL;
      `SMCF_OP_STAT_RD: decode_op = smcf_pkg::SMCF_CMD_STAT_RD;
      `SMCF_OP_STAT_WR: decode_op = smcf_pkg::SMCF_CMD_STAT_WR;
      `SMCF_OP_MEM_RD: decode_op = smcf_pkg::SMCF_CMD_MEM_RD;
      `SMCF_OP_FAST_RD: decode_op = smcf_pkg::SMCF_CMD_FAST_RD;
      `SMCF_OP_MEM_WR: decode_op = smcf_pkg::SMCF_CMD_MEM_WR;
      `SMCF_OP_SLEEP: decode_op = smcf_pkg::SMCF_CMD_SLEEP;
      `SMCF_OP_ID_RD: decode_op = smcf_pkg::SMCF_CMD_ID_RD;
      default: decode_op = smcf_pkg::SMCF_CMD_NONE;
    endcase
  endfunction

  // Two-stage synchronisers for the pins
  logic [1:0] sck_s_q, cs_s_q, si_s_q;
  logic sck_d1_q, cs_d1_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sck_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      si_s_q <= 2'h0;
      sck_d1_q <= 1'b0;
      cs_d1_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[0], sck};
      cs_s_q <= {cs_s_q[0], cs_n};
      si_s_q <= {si_s_q[0], si};
      sck_d1_q <= sck_s_q[1];
      cs_d1_q <= cs_s_q[1];
    end
  end
  wire sck_l = sck_s_q[1];
  wire cs_l = cs_s_q[1];
  wire si_l = si_s_q[1];
  wire cs_fall = cs_d1_q & ~cs_l;
  wire cs_rise = ~cs_d1_q & cs_l;
  wire selected = ~cs_l & ~cs_d1_q;
  wire sck_rise = selected & ~sck_d1_q & sck_l;
  wire sck_fall = selected & sck_d1_q & ~sck_l;

  smcf_pkg::smcf_state_t state_q, state_d;
  logic [2:0] bit_q;
  logic [7:0] shin_q;
  logic [1:0] byte_q;
  logic wl_q;
  logic [7:0] shout_q;
  logic rd_active_q;
  wire [7:0] byte_now = {shin_q[6:0], si_l};
  wire byte_done = sck_rise & (bit_q == `SMCF_LAST_BIT);
  wire smcf_pkg::smcf_cmd_t dec = decode_op(byte_now);
  wire is_stat_rd = cmd_q == smcf_pkg::SMCF_CMD_STAT_RD;
  wire is_rd = cmd_q == smcf_pkg::SMCF_CMD_MEM_RD;
  wire is_fast = cmd_q == smcf_pkg::SMCF_CMD_FAST_RD;
  wire is_wr = cmd_q == smcf_pkg::SMCF_CMD_MEM_WR;
  wire needs_addr = is_rd | is_fast | is_wr;
  wire [7:0] status_byte = 8'h00 | ({7'h00, wl_q} << `SMCF_STAT_WL_BIT);
  wire dummy_done = ~is_fast | (byte_q == `SMCF_FAST_DUMMY);
  wire ends_write = (cmd_q == smcf_pkg::SMCF_CMD_CLR_WL) | is_wr |
    (cmd_q == smcf_pkg::SMCF_CMD_STAT_WR);

  always_comb begin
    state_d = state_q;
    case (state_q)
      smcf_pkg::SMCF_ST_IDLE: begin
        if (cs_fall) begin
          state_d = smcf_pkg::SMCF_ST_OPCODE;
        end
      end
      smcf_pkg::SMCF_ST_OPCODE: begin
        if (byte_done) begin
          if (dec == smcf_pkg::SMCF_CMD_NONE) begin
            state_d = smcf_pkg::SMCF_ST_DISCARD;
          end else if (dec == smcf_pkg::SMCF_CMD_MEM_RD ||
                       dec == smcf_pkg::SMCF_CMD_FAST_RD ||
                       dec == smcf_pkg::SMCF_CMD_MEM_WR) begin
            state_d = smcf_pkg::SMCF_ST_ADDR;
          end else begin
            state_d = smcf_pkg::SMCF_ST_DATA;
          end
        end
      end
      smcf_pkg::SMCF_ST_ADDR: begin
        if (byte_done && byte_q == (`SMCF_ADDR_BYTES - 2'h1)) begin
          state_d = smcf_pkg::SMCF_ST_DATA;
        end
      end
      smcf_pkg::SMCF_ST_DATA: state_d = state_q;
      smcf_pkg::SMCF_ST_DISCARD: state_d = state_q;
      default: state_d = smcf_pkg::SMCF_ST_IDLE;
    endcase
    if (cs_l) begin
      state_d = smcf_pkg::SMCF_ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= smcf_pkg::SMCF_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Mode latch and bit framing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode3_q <= 1'b0;
      bit_q <= 3'h0;
      shin_q <= 8'h00;
    end else begin
      if (cs_fall) begin
        mode3_q <= sck_l;
        bit_q <= 3'h0;
      end else if (sck_rise && state_q != smcf_pkg::SMCF_ST_DISCARD) begin
        bit_q <= bit_q + 3'h1;
        shin_q <= byte_now;
      end
    end
  end

  // Command, address and write data capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_q <= smcf_pkg::SMCF_CMD_NONE;
      cmd_valid_q <= 1'b0;
      byte_q <= 2'h0;
      addr_q <= '0;
      addr_valid_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_strobe_q <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      wr_strobe_q <= 1'b0;
      if (cs_fall) begin
        cmd_q <= smcf_pkg::SMCF_CMD_NONE;
        byte_q <= 2'h0;
        addr_valid_q <= 1'b0;
      end else if (byte_done) begin
        case (state_q)
          smcf_pkg::SMCF_ST_OPCODE: begin
            cmd_q <= dec;
            cmd_valid_q <= dec != smcf_pkg::SMCF_CMD_NONE;
          end
          smcf_pkg::SMCF_ST_ADDR: begin
            addr_q <= ADDR_BITS'({addr_q, byte_now});
            byte_q <= byte_q + 2'h1;
            if (byte_q == (`SMCF_ADDR_BYTES - 2'h1)) begin
              addr_valid_q <= 1'b1;
              byte_q <= 2'h0;
            end
          end
          smcf_pkg::SMCF_ST_DATA: begin
            if (is_wr && wl_q) begin
              wr_data_q <= byte_now;
              wr_strobe_q <= 1'b1;
              addr_q <= addr_q + ADDR_BITS'(1);
            end
            if (is_fast && !dummy_done) begin
              byte_q <= byte_q + 2'h1;
            end
          end
          default: byte_q <= byte_q;
        endcase
      end
    end
  end

  // Write latch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wl_q <= 1'b0;
    end else if (cs_rise && ends_write) begin
      wl_q <= 1'b0;
    end else if (byte_done && state_q == smcf_pkg::SMCF_ST_OPCODE &&
                 dec == smcf_pkg::SMCF_CMD_SET_WL) begin
      wl_q <= 1'b1;
    end
  end

  // Read data shifter; loads on byte boundary, shifts on falling edge
  wire rd_phase = state_q == smcf_pkg::SMCF_ST_DATA &&
    (is_stat_rd || is_rd || (is_fast && dummy_done));
  wire load_out = byte_done && ((state_q == smcf_pkg::SMCF_ST_OPCODE &&
    dec == smcf_pkg::SMCF_CMD_STAT_RD) || (state_q == smcf_pkg::SMCF_ST_ADDR
    && byte_q == (`SMCF_ADDR_BYTES - 2'h1) && is_rd) ||
    (state_q == smcf_pkg::SMCF_ST_DATA && (rd_phase ||
    (is_fast && byte_q == `SMCF_FAST_DUMMY - 2'h1))));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shout_q <= 8'h00;
      rd_active_q <= 1'b0;
      rd_strobe_q <= 1'b0;
      so_o <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      rd_strobe_q <= 1'b0;
      if (cs_l) begin
        rd_active_q <= 1'b0;
        so_oe <= 1'b0;
      end else if (load_out) begin
        shout_q <= is_stat_rd || (state_q == smcf_pkg::SMCF_ST_OPCODE) ?
          status_byte : rd_data;
        rd_active_q <= 1'b1;
        rd_strobe_q <= !(state_q == smcf_pkg::SMCF_ST_OPCODE);
      end else if (sck_fall && rd_active_q) begin
        so_o <= shout_q[7];
        shout_q <= {shout_q[6:0], 1'b0};
        so_oe <= 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      write_latch_flag <= 1'b0;
    end else begin
      write_latch_flag <= wl_q;
    end
  end

  // Checks
  property p_latch_set;
    @(posedge ref_clk) disable iff (rst)
      $rose(wl_q) |-> $past(state_q) == smcf_pkg::SMCF_ST_OPCODE;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch set outside opcode");
  property p_clr_on_rise;
    @(posedge ref_clk) disable iff (rst)
      (cs_rise && ends_write) |=> !wl_q;
  endproperty
  a_clr_on_rise: assert property (p_clr_on_rise)
    else $error("latch not cleared");
  property p_so_off;
    @(posedge ref_clk) disable iff (rst) cs_l |=> !so_oe;
  endproperty
  a_so_off: assert property (p_so_off)
    else $error("output driven while deselected");
  property p_discard;
    @(posedge ref_clk) disable iff (rst)
      state_q == smcf_pkg::SMCF_ST_DISCARD |-> !so_oe && !wr_strobe_q;
  endproperty
  a_discard: assert property (p_discard)
    else $error("activity after invalid opcode");
  property p_mode;
    @(posedge ref_clk) disable iff (rst) cs_fall |=> mode3_q == $past(sck_l);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode not latched");
  property p_wr_needs_latch;
    @(posedge ref_clk) disable iff (rst) wr_strobe_q |-> wl_q;
  endproperty
  a_wr_needs_latch: assert property (p_wr_needs_latch)
    else $error("write without latch");
  // Flag may only rise one cycle after a decoded set latch command
  property p_flag;
    @(posedge ref_clk) disable iff (rst)
      $rose(write_latch_flag) |->
        $past(cmd_valid_q) && $past(cmd_q) == smcf_pkg::SMCF_CMD_SET_WL;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag mismatch");
  property p_oe_only_read;
    @(posedge ref_clk) disable iff (rst) so_oe |-> rd_active_q;
  endproperty
  a_oe_only_read: assert property (p_oe_only_read)
    else $error("output without read");
  c_set: cover property (@(posedge ref_clk) $rose(wl_q));
  c_wr: cover property (@(posedge ref_clk) wr_strobe_q);
  c_rd: cover property (@(posedge ref_clk) $rose(so_oe));
  c_m3: cover property (@(posedge ref_clk) cs_fall && sck_l);
endmodule
`default_nettype wire

// ### hw/smcf_pkg.sv
// Types for the SPI memory command front end
package smcf_pkg;
  typedef enum logic [3:0] {
    SMCF_CMD_NONE = 4'h0,
    SMCF_CMD_SET_WL = 4'h1,
    SMCF_CMD_CLR_WL = 4'h2,
    SMCF_CMD_STAT_RD = 4'h3,
    SMCF_CMD_STAT_WR = 4'h4,
    SMCF_CMD_MEM_RD = 4'h5,
    SMCF_CMD_FAST_RD = 4'h6,
    SMCF_CMD_MEM_WR = 4'h7,
    SMCF_CMD_SLEEP = 4'h8,
    SMCF_CMD_ID_RD = 4'h9
  } smcf_cmd_t;
  typedef enum logic [4:0] {
    SMCF_ST_IDLE = 5'h01,
    SMCF_ST_OPCODE = 5'h02,
    SMCF_ST_ADDR = 5'h04,
    SMCF_ST_DATA = 5'h08,
    SMCF_ST_DISCARD = 5'h10
  } smcf_state_t;
endpackage

// ### test/smcf_spi_master.sv
// Behavioural SPI bus master that drives the front end's serial pins
`timescale 1ns/1ps
`default_nettype none
module smcf_spi_master (
  input wire logic so_o,
  input wire logic so_oe,
  output logic sck,
  output logic cs_n,
  output logic si
);
  localparam realtime HALF = 62.5;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Sends n bytes from the top of tx, zeros past its end; rx is the last
  // byte seen on so
  task automatic frame(input logic m3, input int n, input logic [39:0] tx,
                       output logic [7:0] rx);
    rx = 8'h00;
    sck = m3;
    #HALF;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < 8 * n; i++) begin
      sck = 1'b0;
      si = (i < 40) ? tx[39 - i] : 1'b0;
      #HALF;
      sck = 1'b1;
      rx = {rx[6:0], so_oe ? so_o : 1'bx};
      #HALF;
    end
    sck = m3;
    #HALF;
    cs_n = 1'b1;
    // Released data line must not keep its last value
    si = ~si;
    #(4 * HALF);
  endtask
endmodule
`default_nettype wire

// ### test/spi_memory_command_frontend_tb.sv
// Self-checking bench for the SPI memory command front end
`timescale 1ns/1ps
`default_nettype none
module spi_memory_command_frontend_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rd_data = 8'h00;
  logic sck, cs_n, si, so_o, so_oe, write_latch_flag, mode3_q;
  logic cmd_valid_q, addr_valid_q, wr_strobe_q, rd_strobe_q;
  logic [13:0] addr_q;
  logic [7:0] wr_data_q, rx, d0, d1, op;
  smcf_pkg::smcf_cmd_t cmd_q, last_cmd;
  int mismatches = 0, cmp_count = 0, seed = 79, n_valid = 0, n_wr = 0, nv;
  int n_rd = 0;
  logic [7:0] ops [9] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0b, 8'h02,
                          8'hb9, 8'h9f};
  logic [7:0] bad [5] = '{8'hc3, 8'hc2, 8'h5a, 8'h5b, 8'hff};
  always #5 ref_clk = ~ref_clk;
  smcf_frontend smcf_frontend_i (.ref_clk(ref_clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .rd_data(rd_data), .so_o(so_o), .so_oe(so_oe),
    .write_latch_flag(write_latch_flag), .mode3_q(mode3_q), .cmd_q(cmd_q),
    .cmd_valid_q(cmd_valid_q), .addr_q(addr_q), .addr_valid_q(addr_valid_q),
    .wr_data_q(wr_data_q), .wr_strobe_q(wr_strobe_q),
    .rd_strobe_q(rd_strobe_q));
  smcf_spi_master smcf_spi_master_i (.so_o(so_o), .so_oe(so_oe), .sck(sck),
    .cs_n(cs_n), .si(si));
  always @(posedge ref_clk) begin
    if (cmd_valid_q === 1'b1) begin
      n_valid++;
      last_cmd = cmd_q;
    end
    if (wr_strobe_q === 1'b1) begin
      n_wr++;
      d1 = wr_data_q;
    end
    if (rd_strobe_q === 1'b1) n_rd++;
  end
  function automatic smcf_pkg::smcf_cmd_t exp_cmd(input int i);
    return smcf_pkg::smcf_cmd_t'(i + 1);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cmd(input smcf_pkg::smcf_cmd_t got,
                         input smcf_pkg::smcf_cmd_t exp);
    chk({12'h000, got}, {12'h000, exp});
  endtask
  task automatic run(input logic m3, input int n, input logic [39:0] tx);
    smcf_spi_master_i.frame(m3, n, tx, rx);
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int m = 0; m < 2; m++) begin
      run(m[0], 2, {8'h05, 32'h0});
      chk(rx, 8'h00);
      chk(mode3_q, m[0]);
      run(m[0], 1, {8'h06, 32'h0});
      chk(write_latch_flag, 1'b1);
      chk(rx, 8'hxx);
      chk_cmd(last_cmd, smcf_pkg::SMCF_CMD_SET_WL);
      run(m[0], 2, {8'h05, 32'h0});
      chk(rx, 8'h02);
      run(m[0], 2, {8'h01, 8'hff, 24'h0});
      chk(write_latch_flag, 1'b0);
      d0 = 8'($random(seed));
      rd_data <= 8'($random(seed));
      nv = n_rd;
      run(m[0], 4, {8'h03, 8'hc0, 8'h10, 16'h0});
      chk(rx, rd_data);
      chk(n_rd - nv, 2);
      chk(addr_valid_q, 1'b1);
      chk(addr_q, 14'h0010);
      // Three dummy bytes before the fast read data byte
      run(m[0], 7, {8'h0b, 8'h00, 8'h20, 8'h00, 8'h00});
      chk(rx, rd_data);
      run(m[0], 1, {8'h06, 32'h0});
      run(m[0], 1, {8'h04, 32'h0});
      chk(write_latch_flag, 1'b0);
      run(m[0], 1, {8'h06, 32'h0});
      nv = n_wr;
      run(m[0], 5, {8'h02, 8'hc1, 8'h23, 8'h5a, d0});
      chk(n_wr - nv, 2);
      chk(d1, d0);
      chk(addr_q, 14'h0125);
      chk(write_latch_flag, 1'b0);
      run(m[0], 4, {8'h02, 8'h00, 8'h40, d0, 8'h00});
      chk(n_wr - nv, 2);
    end
    for (int i = 0; i < 9; i++) begin
      nv = n_valid;
      run(i[0], 1, {ops[i], 32'h0});
      chk(n_valid - nv, 1);
      chk_cmd(last_cmd, exp_cmd(i));
    end
    run(1'b0, 1, {8'h04, 32'h0});
    for (int i = 0; i < 9; i++) begin
      op = (i < 5) ? bad[i] : 8'($random(seed));
      foreach (ops[k]) if (ops[k] == op) op = 8'hc3;
      nv = n_valid;
      run(i[0], 3, {op, 8'h06, 8'h05, 16'h0});
      chk(n_valid - nv, 0);
      chk(write_latch_flag, 1'b0);
      chk(rx, 8'hxx);
    end
    run(1'b1, 2, {8'h05, 8'h06, 24'h0});
    chk(write_latch_flag, 1'b0);
    // Reset in mid-run must clear a set latch
    run(1'b0, 1, {8'h06, 32'h0});
    chk(write_latch_flag, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(write_latch_flag, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
